// file: src/sspf_div_if.sv
// Link between the port engine and its bit-rate divider
`timescale 1ns/100ps
`default_nettype none
interface sspf_div_if;
	logic run;
	logic [1:0] primary_prescale;
	logic [2:0] secondary_prescale;
	logic tick;
	modport ctl (output run, output primary_prescale, output secondary_prescale, input tick);
	modport div (input run, input primary_prescale, input secondary_prescale, output tick);
endinterface : sspf_div_if
`default_nettype wire

// file: src/sspf_divider.sv
// Cascaded prescaler giving a one-cycle enable per half bit
`timescale 1ns/100ps
`default_nettype none
module sspf_divider #(
	parameter int unsigned CNT_W = 9
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	sspf_div_if.div dv
);
	import sspf_pkg::*;

	// Counter must reach the widest ratio
	generate
		if ((32'd1 << CNT_W) < SSPF_MAX_RATIO) begin : g_chk
			$error("sspf_divider: CNT_W too small");
		end
	endgenerate

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] lim;

	// Primary and secondary ratios multiply
	assign lim = CNT_W'(sspf_ratio(dv.primary_prescale, dv.secondary_prescale) - 1);

	// Count restarts when stopped so the first step is a full one
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= '0;
		end else if (!dv.run || cnt >= lim) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	assign dv.tick = dv.run && (cnt >= lim);
endmodule : sspf_divider
`default_nettype wire

// file: src/sspf_pkg.sv
// Shared constants, types and decode helpers for the framed serial port
package sspf_pkg;
	localparam int unsigned SSPF_AW = 3;
	localparam int unsigned SSPF_DW = 16;
	// Register indices
	localparam logic [2:0] SSPF_STAT_IDX = 3'h0;
	localparam logic [2:0] SSPF_CON1_IDX = 3'h1;
	localparam logic [2:0] SSPF_CON2_IDX = 3'h2;
	localparam logic [2:0] SSPF_BUF_IDX = 3'h3;
	// Status and enable fields
	localparam int unsigned SSPF_EN_BIT = 15;
	localparam int unsigned SSPF_SIDL_BIT = 13;
	localparam int unsigned SSPF_ROV_BIT = 6;
	localparam int unsigned SSPF_TBF_BIT = 1;
	localparam int unsigned SSPF_RBF_BIT = 0;
	// Control one fields
	localparam int unsigned SSPF_CKDIS_BIT = 12;
	localparam int unsigned SSPF_DODIS_BIT = 11;
	localparam int unsigned SSPF_W16_BIT = 10;
	localparam int unsigned SSPF_SMP_BIT = 9;
	localparam int unsigned SSPF_CKE_BIT = 8;
	localparam int unsigned SSPF_SELECT_PIN_ENABLE_BIT = 7;
	localparam int unsigned SSPF_CKP_BIT = 6;
	localparam int unsigned SSPF_MST_BIT = 5;
	localparam int unsigned SSPF_SPRE_LSB = 2;
	localparam int unsigned SSPF_PPRE_LSB = 0;
	// Control two fields
	localparam int unsigned SSPF_FRM_BIT = 15;
	localparam int unsigned SSPF_FSD_BIT = 14;
	localparam int unsigned SSPF_FPOL_BIT = 13;
	localparam int unsigned SSPF_FDLY_BIT = 1;
	// Writable masks, values after reset and last bit indices per width
	localparam logic [15:0] SSPF_CON1_WMASK = 16'h1fff;
	localparam logic [15:0] SSPF_CON2_WMASK = 16'he002;
	localparam logic [15:0] SSPF_CON1_RST = 16'h0000;
	localparam logic [15:0] SSPF_CON2_RST = 16'h0000;
	localparam logic [15:0] SSPF_WORD_RST = 16'h0000;
	localparam logic [3:0] SSPF_LAST8 = 4'h7;
	localparam logic [3:0] SSPF_LAST16 = 4'hf;
	// Widest divide is 64 x 8 half-bit steps
	localparam int unsigned SSPF_MAX_RATIO = 512;

	typedef enum logic [1:0] {SSPF_IDLE, SSPF_FRAME, SSPF_SHIFT} sspf_state_t;

	// Core cycles per half bit for a prescaler pair
	function automatic int unsigned sspf_ratio(input logic [1:0] p, input logic [2:0] s);
		return (32'd1 << (2 * (3 - int'(p)))) * (8 - int'(s));
	endfunction : sspf_ratio

	// Leading bit of a word in the chosen width
	function automatic logic sspf_msb(input logic [15:0] v, input logic w16);
		return w16 ? v[15] : v[7];
	endfunction : sspf_msb
endpackage : sspf_pkg

// file: src/sspf_port.sv
// Framed serial port: registers, shift engine and pin control
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1: Data shifts through a 16-bit shift register; software uses a buffer window.
// RQ2: Enable bit 15 hands the four pins to the port; clear disables it.
// RQ3: With halt-in-idle set, the port freezes while the processor idles.
// RQ4: A word completing while receive data is unread is dropped and flags overflow.
// RQ5: Transmit-full sets on buffer write, clears when the word enters the shifter.
// RQ6: Receive-full sets when a word reaches receive holding, clears on buffer read.
// RQ7: As master, clock-pin disable keeps the clock off its pin.
// RQ8: Data-out disable releases the data output pin.
// RQ9: Width bit picks 16-bit words when set, 8-bit when clear.
// RQ10: Master samples input at end of bit when sample phase set, middle otherwise.
// RQ11: Software keeps sample phase clear in slave operation.
// RQ12: Edge bit set: data changes active-to-idle; clear: idle-to-active.
// RQ13: Polarity set gives idle-high clock; clear gives idle-low.
// RQ14: Slave with select enable uses the active-low select pin.
// RQ15: Master enable set drives the clock out; clear takes clock as input.
// RQ16: Software never sets both prescalers to one-to-one together.
// RQ17: Framed mode turns the select pin into a frame sync pulse.
// RQ18: Framed mode needs edge bit zero and select enable clear.
// RQ19: Frame direction set makes the pulse an input, clear an output.
// RQ20: Frame polarity set makes the pulse active-high, clear active-low.
// RQ21: Frame edge set puts the pulse on bit one, clear one bit ahead.
// RQ22: Master clock comes from a primary then secondary prescaler.
module sspf_port (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [sspf_pkg::SSPF_AW-1:0] reg_addr,
	input wire logic [sspf_pkg::SSPF_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sspf_pkg::SSPF_DW-1:0] reg_rdata,
	input wire logic cpu_idle,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	input wire logic serial_in_pin_in,
	output logic serial_out_pin_out,
	output logic serial_out_pin_oe,
	input wire logic select_low_pin_in,
	output logic select_low_pin_out,
	output logic select_low_pin_oe
);
	import sspf_pkg::*;

	logic [15:0] con1;
	logic [15:0] con2;
	logic port_enable;
	logic halt_in_idle;
	logic receive_overflow_flag;
	logic transmit_full_flag;
	logic receive_full_flag;
	logic [15:0] transmit_holding;
	logic [15:0] receive_holding;
	logic [15:0] serial_shift_register;
	sspf_state_t state;
	logic [3:0] bit_cnt;
	logic half;
	logic sck_lvl;
	logic dout;
	logic armed;
	logic s_loaded;
	logic [2:0] pin_m;
	logic [2:0] pin_s;
	logic sck_d;

	// Field decode of the two control registers
	logic clock_pin_disable, data_out_pin_disable, word_width_select, sample_phase;
	logic out_edge_select, select_pin_enable, clock_polarity, master_enable;
	logic framed_enable, frame_pulse_direction, frame_pulse_polarity, frame_pulse_edge;
	assign clock_pin_disable = con1[SSPF_CKDIS_BIT];
	assign data_out_pin_disable = con1[SSPF_DODIS_BIT];
	assign word_width_select = con1[SSPF_W16_BIT];
	assign sample_phase = con1[SSPF_SMP_BIT];
	assign out_edge_select = con1[SSPF_CKE_BIT];
	assign select_pin_enable = con1[SSPF_SELECT_PIN_ENABLE_BIT];
	assign clock_polarity = con1[SSPF_CKP_BIT];
	assign master_enable = con1[SSPF_MST_BIT];
	assign framed_enable = con2[SSPF_FRM_BIT];
	assign frame_pulse_direction = con2[SSPF_FSD_BIT];
	assign frame_pulse_polarity = con2[SSPF_FPOL_BIT];
	assign frame_pulse_edge = con2[SSPF_FDLY_BIT];

	// Bus decode
	logic buf_wr, buf_rd, stat_wr;
	assign buf_wr = reg_wr && reg_addr == SSPF_BUF_IDX;
	assign buf_rd = reg_rd && reg_addr == SSPF_BUF_IDX;
	assign stat_wr = reg_wr && reg_addr == SSPF_STAT_IDX;

	// Pins pass two flops; the second stage feeds logic, and a third flop on the clock gives edge detect
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_m <= 3'h0;
			pin_s <= 3'h0;
			sck_d <= 1'b0;
		end else begin
			pin_m <= {select_low_pin_in, serial_in_pin_in, shift_clock_pin_in};
			pin_s <= pin_m;
			sck_d <= pin_s[0];
		end
	end

	logic sck_s, sdi_s, ss_s;
	assign sck_s = pin_s[0];
	assign sdi_s = pin_s[1];
	assign ss_s = pin_s[2];

	// Mode terms; the edge bit is ignored when framed
	logic run, cke_eff, first_lvl, framed_in, frame_out, fs_act, sel_nf;
	logic [3:0] last_bit;
	assign run = port_enable && !(halt_in_idle && cpu_idle); // RQ3
	assign cke_eff = out_edge_select && !framed_enable; // RQ18
	assign first_lvl = cke_eff ? clock_polarity : !clock_polarity; // RQ12
	assign framed_in = framed_enable && frame_pulse_direction; // RQ19
	assign frame_out = framed_enable && !frame_pulse_direction; // RQ19
	assign fs_act = ss_s == frame_pulse_polarity; // RQ20
	assign sel_nf = select_pin_enable ? !ss_s : 1'b1; // RQ14
	assign last_bit = word_width_select ? SSPF_LAST16 : SSPF_LAST8; // RQ9

	// Divider hookup
	sspf_div_if dvi ();
	logic tick;
	assign dvi.run = run && master_enable;
	assign dvi.primary_prescale = con1[SSPF_PPRE_LSB +: 2]; // RQ22
	assign dvi.secondary_prescale = con1[SSPF_SPRE_LSB +: 3]; // RQ22
	assign tick = dvi.tick;

	sspf_divider #(.CNT_W(9)) u_div (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.dv(dvi)
	);

	// Shifted value with the newly sampled bit
	logic [15:0] nsr;
	assign nsr = {serial_shift_register[14:0], sdi_s}; // RQ1

	// Master events
	logic m_start, m_samp, m_done;
	assign m_start = run && master_enable && state == SSPF_IDLE && tick
		&& transmit_full_flag && (!framed_in || fs_act);
	assign m_samp = state == SSPF_SHIFT && tick && (half ? sample_phase : !sample_phase); // RQ10
	assign m_done = state == SSPF_SHIFT && tick && half && bit_cnt == last_bit;

	// Slave events from the sampled clock
	logic sck_chg, to_active, to_idle, s_samp_edge, s_chg_edge, s_take, s_samp;
	logic s_arm, s_load, s_done;
	assign sck_chg = sck_s != sck_d;
	assign to_active = sck_chg && sck_s != clock_polarity; // RQ13
	assign to_idle = sck_chg && sck_s == clock_polarity; // RQ13
	assign s_samp_edge = cke_eff ? to_active : to_idle; // RQ12
	assign s_chg_edge = cke_eff ? to_idle : to_active; // RQ12
	assign s_take = framed_in ? (armed || (frame_pulse_edge && fs_act)) : sel_nf; // RQ21
	assign s_samp = run && !master_enable && s_samp_edge && s_take;
	assign s_arm = run && !master_enable && framed_in && s_samp_edge && !armed
		&& !frame_pulse_edge && fs_act; // RQ21
	assign s_load = run && !master_enable && bit_cnt == 4'h0 && !s_loaded
		&& transmit_full_flag && !s_samp_edge && (framed_in || sel_nf);
	assign s_done = s_samp && bit_cnt == last_bit;

	logic tx_take, word_done, ovf_cond;
	assign tx_take = m_start || s_load; // RQ5
	assign word_done = m_done || s_done; // RQ6
	assign ovf_cond = receive_full_flag && !buf_rd; // RQ4

	// Completed word as it lands in receive holding
	logic [15:0] rx_word;
	logic [15:0] done_sr;
	assign done_sr = (m_done && !m_samp) ? serial_shift_register : nsr;
	assign rx_word = word_width_select ? done_sr : {8'h00, done_sr[7:0]}; // RQ9

	// Control registers and enable bits
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			con1 <= SSPF_CON1_RST;
			con2 <= SSPF_CON2_RST;
			port_enable <= 1'b0;
			halt_in_idle <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == SSPF_CON1_IDX) begin
				con1 <= reg_wdata & SSPF_CON1_WMASK;
			end
			if (reg_addr == SSPF_CON2_IDX) begin
				con2 <= reg_wdata & SSPF_CON2_WMASK;
			end
			if (stat_wr) begin
				port_enable <= reg_wdata[SSPF_EN_BIT]; // RQ2
				halt_in_idle <= reg_wdata[SSPF_SIDL_BIT]; // RQ3
			end
		end
	end

	// Transmit side; a write in the same cycle as a take keeps the flag set
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			transmit_holding <= SSPF_WORD_RST;
			transmit_full_flag <= 1'b0;
		end else begin
			if (buf_wr) begin
				transmit_holding <= reg_wdata;
				transmit_full_flag <= 1'b1; // RQ5
			end else if (tx_take) begin
				transmit_full_flag <= 1'b0; // RQ5
			end
		end
	end

	// Receive side; arrival beats a same-cycle clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			receive_holding <= SSPF_WORD_RST;
			receive_full_flag <= 1'b0;
			receive_overflow_flag <= 1'b0;
		end else begin
			if (word_done && !ovf_cond) begin
				receive_holding <= rx_word;
				receive_full_flag <= 1'b1; // RQ6
			end else if (buf_rd) begin
				receive_full_flag <= 1'b0; // RQ6
			end
			if (word_done && ovf_cond) begin
				receive_overflow_flag <= 1'b1; // RQ4
			end else if (stat_wr && !reg_wdata[SSPF_ROV_BIT]) begin
				receive_overflow_flag <= 1'b0; // RQ4
			end
		end
	end

	// Shift engine; halting freezes it mid-word rather than aborting
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= SSPF_IDLE;
			serial_shift_register <= SSPF_WORD_RST;
			bit_cnt <= 4'h0;
			half <= 1'b0;
			sck_lvl <= 1'b0;
			dout <= 1'b0;
			armed <= 1'b0;
			s_loaded <= 1'b0;
		end else if (!port_enable) begin
			state <= SSPF_IDLE;
			bit_cnt <= 4'h0;
			half <= 1'b0;
			sck_lvl <= clock_polarity;
			armed <= 1'b0;
			s_loaded <= 1'b0;
		end else if (run && master_enable) begin
			unique case (state)
				SSPF_IDLE: begin
					sck_lvl <= clock_polarity; // RQ13
					if (m_start) begin
						serial_shift_register <= transmit_holding; // RQ1
						dout <= sspf_msb(transmit_holding, word_width_select);
						half <= 1'b0;
						bit_cnt <= 4'h0;
						sck_lvl <= first_lvl; // RQ12
						state <= (frame_out && !frame_pulse_edge) ? SSPF_FRAME : SSPF_SHIFT; // RQ21
					end
				end
				SSPF_FRAME: begin
					if (tick) begin
						half <= !half;
						sck_lvl <= half ? first_lvl : !first_lvl;
						if (half) begin
							state <= SSPF_SHIFT;
						end
					end
				end
				SSPF_SHIFT: begin
					if (m_samp) begin
						serial_shift_register <= nsr; // RQ10
					end
					if (tick && !half) begin
						half <= 1'b1;
						sck_lvl <= !first_lvl; // RQ12
					end else if (tick && bit_cnt == last_bit) begin
						state <= SSPF_IDLE;
						half <= 1'b0;
						bit_cnt <= 4'h0;
						sck_lvl <= clock_polarity; // RQ13
					end else if (tick) begin
						half <= 1'b0;
						bit_cnt <= bit_cnt + 4'h1;
						sck_lvl <= first_lvl; // RQ12
						dout <= sspf_msb(m_samp ? nsr : serial_shift_register, word_width_select);
					end
				end
				default: begin
					state <= SSPF_IDLE;
				end
			endcase
		end else if (run) begin
			state <= SSPF_IDLE;
			sck_lvl <= clock_polarity;
			if (!framed_in && !sel_nf) begin
				bit_cnt <= 4'h0; // RQ14
				s_loaded <= 1'b0;
			end else begin
				if (s_load) begin
					serial_shift_register <= transmit_holding;
					dout <= sspf_msb(transmit_holding, word_width_select);
					s_loaded <= 1'b1;
				end
				if (s_samp) begin
					serial_shift_register <= nsr; // RQ15
					if (s_done) begin
						bit_cnt <= 4'h0;
						s_loaded <= 1'b0;
						armed <= 1'b0;
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				if (s_arm) begin
					armed <= 1'b1; // RQ21
				end
				if (s_chg_edge) begin
					dout <= sspf_msb(serial_shift_register, word_width_select); // RQ12
				end
			end
		end
	end

	// Frame pulse spans one bit clock
	logic frame_act;
	assign frame_act = state == SSPF_FRAME
		|| (state == SSPF_SHIFT && frame_pulse_edge && bit_cnt == 4'h0); // RQ21

	// Pin drive
	assign shift_clock_pin_out = sck_lvl;
	assign shift_clock_pin_oe = port_enable && master_enable && !clock_pin_disable; // RQ7 RQ15
	assign serial_out_pin_out = dout;
	assign serial_out_pin_oe = port_enable && !data_out_pin_disable
		&& (master_enable || framed_enable || sel_nf); // RQ8
	assign select_low_pin_out = frame_act ? frame_pulse_polarity : !frame_pulse_polarity; // RQ20
	assign select_low_pin_oe = port_enable && frame_out; // RQ17 RQ19

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= SSPF_WORD_RST;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			unique case (reg_addr)
				SSPF_STAT_IDX: begin
					reg_rdata[SSPF_EN_BIT] <= port_enable;
					reg_rdata[SSPF_SIDL_BIT] <= halt_in_idle;
					reg_rdata[SSPF_ROV_BIT] <= receive_overflow_flag;
					reg_rdata[SSPF_TBF_BIT] <= transmit_full_flag;
					reg_rdata[SSPF_RBF_BIT] <= receive_full_flag;
				end
				SSPF_CON1_IDX: reg_rdata <= con1;
				SSPF_CON2_IDX: reg_rdata <= con2;
				SSPF_BUF_IDX: reg_rdata <= receive_holding;
				default: reg_rdata <= '0;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_frame_lead;
		m_start && frame_out && !frame_pulse_edge;
	endsequence
	sequence seq_master_end;
		m_done && master_enable;
	endsequence

	a_tx_full_set: // RQ5
	assert property (buf_wr |=> transmit_full_flag && transmit_holding == $past(reg_wdata))
		else $error("transmit full not set by write");
	a_tx_full_clear: // RQ5
	assert property (tx_take && !buf_wr |=> !transmit_full_flag)
		else $error("transmit full not cleared on take");
	a_rx_full_set: // RQ6
	assert property (word_done && !ovf_cond |=> receive_full_flag
		&& receive_holding == $past(rx_word))
		else $error("received word not stored");
	a_rx_read_clear: // RQ6
	assert property (buf_rd && !word_done |=> !receive_full_flag)
		else $error("receive full not cleared by read");
	a_rx_overflow_drop: // RQ4
	assert property (word_done && ovf_cond |=> receive_overflow_flag && $stable(receive_holding))
		else $error("overflow word not discarded");
	a_port_off_pins: // RQ2
	assert property (!port_enable |-> !shift_clock_pin_oe && !serial_out_pin_oe
		&& !select_low_pin_oe)
		else $error("pins driven while disabled");
	a_clock_pin_off: // RQ7
	assert property (clock_pin_disable |-> !shift_clock_pin_oe)
		else $error("clock pin driven while disabled");
	a_data_pin_off: // RQ8
	assert property (data_out_pin_disable |-> !serial_out_pin_oe)
		else $error("data pin driven while disabled");
	a_idle_freeze: // RQ3
	assert property (port_enable && halt_in_idle && cpu_idle && master_enable
		|=> $stable(state) && $stable(bit_cnt) && $stable(sck_lvl))
		else $error("engine moved while halted");
	a_master_end_idle: // RQ13
	assert property (seq_master_end |=> state == SSPF_IDLE && sck_lvl == clock_polarity)
		else $error("clock not idle after word");
	a_frame_lead_pulse: // RQ21
	assert property (seq_frame_lead |=> state == SSPF_FRAME
		&& select_low_pin_out == frame_pulse_polarity)
		else $error("leading frame pulse missing");
endmodule : sspf_port
`default_nettype wire

// file: verif/sspf_peer.sv
// Behavioural far-side peer that shifts words against the port's clock pin
`timescale 1ns/100ps
`default_nettype none
module sspf_peer (
	input wire logic sck,
	input wire logic cpol,
	input wire logic w16,
	input wire logic hold,
	input wire logic mosi,
	input wire logic [15:0] tx_word,
	output logic miso,
	output logic [15:0] rx_word
);
	logic [4:0] cnt = 5'h00;
	logic [15:0] sh = 16'h0000;
	initial begin
		miso = 1'b0;
		rx_word = 16'h0000;
	end
	// Restart the bit count before each word, since config changes can wiggle the pin;
	// the line shows the inverse of the last bit until the first new bit goes out
	always @(posedge hold) begin
		cnt = 5'h00;
		miso <= ~miso;
	end
	// Leading bit first; the last bit stays on the line to the end of its bit time
	always @(sck) begin
		if (!hold && sck !== cpol && cnt < (w16 ? 5'd16 : 5'd8)) begin
			miso <= tx_word[(w16 ? 5'd15 : 5'd7) - cnt];
		end else if (!hold && sck === cpol && cnt < (w16 ? 5'd16 : 5'd8)) begin
			sh = {sh[14:0], mosi};
			cnt = cnt + 5'd1;
			if (cnt == (w16 ? 5'd16 : 5'd8)) begin
				rx_word <= w16 ? sh : {8'h00, sh[7:0]};
			end
		end
	end
endmodule : sspf_peer
`default_nettype wire

// file: verif/sspf_port_tb.sv
// Self-checking bench for the framed serial port
`timescale 1ns/100ps
`default_nettype none
module sspf_port_tb;
	import sspf_pkg::*;
	logic core_clk, sys_rst, reg_wr, reg_rd, cpu_idle, pclr, cpol, w16, hit;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ptx, prx, v;
	logic sck_o, sck_oe, sdo, sdo_oe, sel_o, sel_oe, miso, sck_w, sel_w, bsck;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Released clock pin carries the bench's slave clock, idle low; released select pulled high
	assign sck_w = sck_oe ? sck_o : bsck;
	assign sel_w = sel_oe ? sel_o : 1'b1;
	sspf_port sspf_port_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_idle(cpu_idle), .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_o),
		.shift_clock_pin_oe(sck_oe), .serial_in_pin_in(miso), .serial_out_pin_out(sdo),
		.serial_out_pin_oe(sdo_oe), .select_low_pin_in(sel_w), .select_low_pin_out(sel_o),
		.select_low_pin_oe(sel_oe));
	sspf_peer sspf_peer_i (.sck(sck_w), .cpol(cpol), .w16(w16), .hold(pclr), .mosi(sdo),
		.tx_word(ptx), .miso(miso), .rx_word(prx));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Hang guard, well above the thousand or so cycles the tests need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
			num_errors++;
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// Step past the write edge so pin checks see the updated registers
		#1;
	endtask : wr
	// Read data is valid from the cycle after the strobe until the next read
	task automatic rdchk(input logic [2:0] a, input logic [15:0] e, input string m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		chk(v, e, m);
	endtask : rdchk
	// Poll status under a bound; a miss counts as a mismatch
	task automatic wait_stat(input logic [15:0] mask, input logic [15:0] e);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge core_clk);
			reg_addr <= SSPF_STAT_IDX;
			reg_rd <= 1'b1;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1;
			if ((reg_rdata & mask) === e) break;
		end
		chk(reg_rdata & mask, e, "status wait");
	endtask : wait_stat
	task automatic xfer(input logic [15:0] tx, input logic [15:0] pw);
		pclr <= 1'b1;
		ptx <= pw;
		@(posedge core_clk);
		pclr <= 1'b0;
		wr(SSPF_BUF_IDX, tx);
	endtask : xfer
	initial begin
		{reg_wr, reg_rd, cpu_idle, pclr, cpol, w16, bsck} = 7'h00;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		ptx = 16'h0000;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		// Reset values, writable masks, unmapped index
		rdchk(SSPF_STAT_IDX, 16'h0000, "stat reset");
		chk(16'({sck_oe, sdo_oe, sel_oe}), 16'h0000, "pins idle");
		wr(SSPF_CON1_IDX, 16'hffff);
		rdchk(SSPF_CON1_IDX, SSPF_CON1_WMASK, "con1 mask");
		wr(SSPF_CON2_IDX, 16'hffff);
		rdchk(SSPF_CON2_IDX, SSPF_CON2_WMASK, "con2 mask");
		wr(3'h5, 16'hffff);
		rdchk(3'h5, 16'h0000, "unmapped");
		wr(SSPF_CON2_IDX, 16'h0000);
		$display("test regs done");
		// Master, 8-bit, ratio 4, sample phase clear, prescalers not both 1:1
		wr(SSPF_CON1_IDX, 16'h0033);
		wr(SSPF_STAT_IDX, 16'h8000);
		chk(16'({sck_oe, sdo_oe, sck_o}), 16'h0006, "master pins");
		xfer(16'h00a5, 16'h003c);
		wait_stat(16'h0003, 16'h0001);
		chk(prx, 16'h00a5, "peer got");
		rdchk(SSPF_BUF_IDX, 16'h003c, "rx word");
		rdchk(SSPF_STAT_IDX, 16'h8000, "rx full clr");
		$display("test master8 done");
		// Second word while first unread is dropped
		xfer(16'h0011, 16'h003c);
		wait_stat(16'h0001, 16'h0001);
		xfer(16'h0022, 16'h00c3);
		wait_stat(16'h0040, 16'h0040);
		chk(prx, 16'h0022, "peer second");
		rdchk(SSPF_BUF_IDX, 16'h003c, "kept first");
		wr(SSPF_STAT_IDX, 16'h8000);
		rdchk(SSPF_STAT_IDX, 16'h8000, "ovf clr");
		$display("test overflow done");
		// Master sampling at the end of each bit time
		wr(SSPF_CON1_IDX, 16'h0233);
		xfer(16'h005a, 16'h0096);
		wait_stat(16'h0003, 16'h0001);
		chk(prx, 16'h005a, "peer smp");
		rdchk(SSPF_BUF_IDX, 16'h0096, "rx smp");
		$display("test smpend done");
		// Slave, 8-bit, clock from the bench at the link period, select pin unused
		wr(SSPF_CON1_IDX, 16'h0000);
		chk(16'({sck_oe, sdo_oe}), 16'h0001, "slave pins");
		xfer(16'h00c6, 16'h0069);
		repeat (16) begin
			repeat (4) @(posedge core_clk);
			bsck <= ~bsck;
		end
		wait_stat(16'h0003, 16'h0001);
		chk(prx, 16'h00c6, "peer slave");
		rdchk(SSPF_BUF_IDX, 16'h0069, "rx slave");
		$display("test slave done");
		// 16-bit, idle-high clock
		wr(SSPF_STAT_IDX, 16'h0000);
		cpol <= 1'b1;
		w16 <= 1'b1;
		wr(SSPF_CON1_IDX, 16'h0473);
		wr(SSPF_STAT_IDX, 16'h8000);
		chk(16'(sck_o), 16'h0001, "idle high");
		xfer(16'h1234, 16'hbeef);
		wait_stat(16'h0003, 16'h0001);
		chk(prx, 16'h1234, "peer 16");
		rdchk(SSPF_BUF_IDX, 16'hbeef, "rx 16");
		$display("test width16 done");
		// Halt while the processor idles, then resume
		wr(SSPF_STAT_IDX, 16'ha000);
		@(posedge core_clk);
		cpu_idle <= 1'b1;
		xfer(16'h0055, 16'h0000);
		repeat (100) @(posedge core_clk);
		rdchk(SSPF_STAT_IDX, 16'ha002, "frozen");
		@(posedge core_clk);
		cpu_idle <= 1'b0;
		wait_stat(16'h0003, 16'h0001);
		rdchk(SSPF_BUF_IDX, 16'h0000, "rx idle");
		chk(prx, 16'h0055, "peer idle");
		$display("test halt done");
		// Pin release by disable bits
		wr(SSPF_STAT_IDX, 16'h0000);
		chk(16'({sck_oe, sdo_oe}), 16'h0000, "off pins");
		wr(SSPF_CON1_IDX, 16'h1873);
		wr(SSPF_STAT_IDX, 16'h8000);
		chk(16'(sck_oe), 16'h0000, "clk off");
		chk(16'(sdo_oe), 16'h0000, "dout off");
		$display("test pindis done");
		// Framed master, active-high pulse, edge bit and select enable clear
		wr(SSPF_STAT_IDX, 16'h0000);
		cpol <= 1'b0;
		w16 <= 1'b0;
		wr(SSPF_CON1_IDX, 16'h0033);
		wr(SSPF_CON2_IDX, 16'ha000);
		wr(SSPF_STAT_IDX, 16'h8000);
		chk(16'({sel_oe, sel_o}), 16'h0002, "frame idle");
		hit = 1'b0;
		xfer(16'h0077, 16'h0000);
		repeat (300) begin
			@(posedge core_clk);
			if (sel_o === 1'b1) hit = 1'b1;
		end
		chk(16'(hit), 16'h0001, "frame pulse");
		wait_stat(16'h0003, 16'h0001);
		$display("test framed done");
		end_sim();
	end
endmodule : sspf_port_tb
`default_nettype wire
